// File: bench/srq_controller_model.sv
// Bus controller that serial-polls the device whenever it requests service.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Controller model
module srq_controller_model
(
  input  wire logic       clk,
  input  wire logic       auto_poll,
  input  wire logic       srq_oe,
  input  wire logic       poll_valid,
  input  wire logic [7:0] poll_data,
  output var  logic       serial_poll,
  output var  logic       requester
);
  logic waiting = 1'b0;
  initial serial_poll = 1'b0;
  // One poll per request; waiting blocks a second poll while the answer is due.
  always @(negedge clk)
  begin
    serial_poll <= 1'b0;
    if (poll_valid)
    begin
      requester <= poll_data[6];
      waiting <= 1'b0;
    end
    else if (auto_poll && srq_oe && !waiting)
    begin
      serial_poll <= 1'b1;
      waiting <= 1'b1;
    end
  end
endmodule // srq_controller_model
`default_nettype wire

// File: bench/status_byte_service_request_tb.sv
// Self-checking testbench of the status summary and service request block.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Testbench
module status_byte_service_request_tb;
  logic clk, rst, cmd_err, exe_err, qry_err, msg_available, ops_pending;
  logic ese_write, oper_en_write, sre_write, esr_read, oper_read, stb_query;
  logic clear_status, opc_cmd, opc_query, auto_poll, serial_poll, requester;
  logic reply_valid, poll_valid, srq_oe, bus_hold, opc_answer_push;
  logic [7:0] oper_events, write_data, service_request_mask, reply_data;
  logic [7:0] poll_data, opc_answer_data;
  logic [7:0] std_event_enable, oper_event_enable;
  logic srq_out;
  int n_errors = 0;
  int n_compared = 0;
  status_byte_service_request u_status_byte_service_request
  (
    .clk, .rst, .cmd_err, .exe_err, .qry_err, .oper_events, .msg_available,
    .ops_pending, .ese_write, .oper_en_write, .sre_write, .write_data,
    .esr_read, .oper_read, .clear_status, .stb_query, .serial_poll, .opc_cmd,
    .opc_query, .service_request_mask, .std_event_enable,
    .oper_event_enable, .reply_data, .reply_valid, .poll_data, .poll_valid,
    .srq_out, .srq_oe, .bus_hold, .opc_answer_push, .opc_answer_data
  );
  srq_controller_model u_srq_controller_model
  (
    .clk, .auto_poll, .srq_oe, .poll_valid, .poll_data, .serial_poll,
    .requester
  );
  task automatic chk(input string what, input logic [7:0] exp, got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(ref logic s, input logic [7:0] d = 8'h00);
    @(negedge clk);
    s = 1'b1;
    write_data = d;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic ask(ref logic s, input logic [7:0] exp, input string what);
    // The reply pulse stands only in the cycle right after the request.
    pulse(s);
    chk(what, exp, reply_valid === 1'b1 ? reply_data : 8'hxx);
  endtask
  // Bounded wait; a miss is reported like any other mismatch.
  task automatic wait_for(ref logic s);
    for (int i = 0; i < 40 && s !== 1'b1; i++) @(negedge clk);
    chk("wait", 8'h01, 8'(s));
  endtask
  task automatic finish_test;
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #100000;
    n_errors++;
    finish_test;
  end
  initial
  begin
    {cmd_err, exe_err, qry_err, msg_available, ops_pending, ese_write} = '0;
    {oper_en_write, sre_write, esr_read, oper_read, stb_query} = '0;
    {clear_status, opc_cmd, opc_query, oper_events, write_data} = '0;
    rst = 1'b1;
    auto_poll = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    ask(esr_read, 8'h80, "esr");
    ask(esr_read, 8'h00, "esr");
    pulse(sre_write, 8'h20);
    pulse(ese_write, 8'h20);
    chk("ese", 8'h20, std_event_enable);
    pulse(cmd_err);
    wait_for(srq_oe);
    wait_for(poll_valid);
    chk("poll", 8'h60, poll_data);
    @(negedge clk);
    chk("req", 8'h01, 8'(requester));
    chk("srq", 8'h00, 8'(srq_oe));
    chk("srq_out", 8'h00, 8'(srq_out));
    pulse(cmd_err);
    ask(stb_query, 8'h60, "stb");
    chk("srq", 8'h00, 8'(srq_oe));
    ask(esr_read, 8'h20, "esr");
    ask(stb_query, 8'h00, "stb");
    pulse(cmd_err);
    wait_for(poll_valid);
    chk("poll", 8'h60, poll_data);
    ask(esr_read, 8'h20, "esr");
    msg_available = 1'b1;
    pulse(sre_write, 8'h10);
    chk("mask", 8'h10, service_request_mask);
    wait_for(poll_valid);
    chk("poll", 8'h50, poll_data);
    msg_available = 1'b0;
    ask(stb_query, 8'h00, "stb");
    pulse(sre_write, 8'hff);
    chk("mask", 8'hb0, service_request_mask);
    pulse(sre_write, 8'h00);
    chk("mask", 8'h00, service_request_mask);
    pulse(oper_en_write, 8'h01);
    chk("oee", 8'h01, oper_event_enable);
    oper_events = 8'h01;
    @(negedge clk);
    oper_events = 8'h00;
    pulse(ese_write, 8'h14);
    pulse(exe_err);
    pulse(qry_err);
    ask(stb_query, 8'ha0, "stb");
    pulse(clear_status);
    ask(stb_query, 8'h00, "stb");
    oper_events = 8'h02;
    @(negedge clk);
    oper_events = 8'h00;
    ask(oper_read, 8'h02, "oper");
    ask(oper_read, 8'h00, "oper");
    pulse(exe_err);
    pulse(qry_err);
    ask(esr_read, 8'h14, "esr");
    ops_pending = 1'b1;
    pulse(ese_write, 8'h01);
    pulse(opc_cmd);
    ask(stb_query, 8'h00, "stb");
    ops_pending = 1'b0;
    repeat (3) @(negedge clk);
    ask(esr_read, 8'h01, "esr");
    ops_pending = 1'b1;
    pulse(opc_query);
    // The hold passes a second register stage before it reaches the port.
    @(negedge clk);
    chk("hold", 8'h01, 8'(bus_hold));
    ops_pending = 1'b0;
    wait_for(opc_answer_push);
    chk("opc", 8'h01, opc_answer_data);
    ask(esr_read, 8'h00, "esr");
    finish_test;
  end
endmodule // status_byte_service_request_tb
`default_nettype wire

// File: bench/status_srq_assertions.sv
// Port-level checks of the status summary and service request block.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Checker
module status_srq_assertions
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       sre_write,
  input wire logic [7:0] write_data,
  input wire logic       esr_read,
  input wire logic       oper_read,
  input wire logic       stb_query,
  input wire logic       serial_poll,
  input wire logic [7:0] service_request_mask,
  input wire logic [7:0] reply_data,
  input wire logic       reply_valid,
  input wire logic [7:0] poll_data,
  input wire logic       poll_valid,
  input wire logic       srq_oe,
  input wire logic       bus_hold,
  input wire logic       opc_answer_push,
  input wire logic [7:0] opc_answer_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence poll_s;
    serial_poll ##1 poll_valid;
  endsequence
  poll_answer_a: assert property (serial_poll |=> poll_valid)
    else $error("poll answer missing");
  poll_withdraw_a: assert property (poll_s |-> !srq_oe)
    else $error("request kept after poll");
  poll_low_a: assert property (
    poll_valid |-> poll_data[3:0] == 4'h0) else $error("poll low bits set");
  query_low_a: assert property (
    stb_query && !esr_read && !oper_read
    |=> reply_valid && reply_data[3:0] == 4'h0)
    else $error("bad query reply");
  esr_answer_a: assert property (esr_read |=> reply_valid)
    else $error("event read answer missing");
  mask_write_a: assert property (sre_write |=>
    service_request_mask == ($past(write_data) & 8'hb0)) else $error("mask");
  opc_data_a: assert property (
    opc_answer_push |-> opc_answer_data == 8'h01)
    else $error("completion answer value");
  hold_drop_a: assert property (opc_answer_push |=> !bus_hold)
    else $error("bus held after answer");
endmodule // status_srq_assertions
bind status_byte_service_request status_srq_assertions u_status_srq_assertions
(
  .clk, .rst, .sre_write, .write_data, .esr_read, .oper_read, .stb_query,
  .serial_poll, .service_request_mask, .reply_data, .reply_valid, .poll_data,
  .poll_valid, .srq_oe, .bus_hold, .opc_answer_push, .opc_answer_data
);
`default_nettype wire

// File: src/opc_tracker.v
// Operation-complete tracker for the command and query forms.
`timescale 1ns/1ps
`default_nettype none
module opc_tracker
(
  input  wire clk,
  input  wire rst,
  input  wire opc_cmd,
  input  wire opc_query,
  input  wire ops_pending,
  output reg  opc_event,
  output reg  opc_answer,
  output reg  bus_hold
);
  reg cmd_wait_r;
  reg qry_wait_r;

  // Both forms may be outstanding at once; each retires independently.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_wait_r <= 1'b0;
      qry_wait_r <= 1'b0;
      opc_event  <= 1'b0;
      opc_answer <= 1'b0;
      bus_hold   <= 1'b0;
    end
    else
    begin
      opc_event  <= 1'b0;
      opc_answer <= 1'b0;
      if (opc_cmd)
        cmd_wait_r <= 1'b1;
      else if (cmd_wait_r && !ops_pending)
      begin
        cmd_wait_r <= 1'b0;
        opc_event  <= 1'b1; // [RULE12]
      end
      if (opc_query)
      begin
        qry_wait_r <= 1'b1;
        bus_hold   <= 1'b1; // [RULE13]
      end
      else if (qry_wait_r && !ops_pending)
      begin
        qry_wait_r <= 1'b0;
        bus_hold   <= 1'b0;
        opc_answer <= 1'b1; // [RULE13]
      end
    end
  end
endmodule // opc_tracker
`default_nettype wire

// File: src/status_byte_service_request.v
// Status byte, service request enable and serial poll logic.
`timescale 1ns/1ps
`default_nettype none
`include "status_srq_consts.vh"

// Functional notes
// RULE1: Summary bits follow their sources combinationally, never latched.
// RULE2: Bit 4 is set exactly while the output buffer holds data.
// RULE3: Bit 7 is OR of enabled operation events.
// RULE4: Bit 5 is OR of enabled standard events.
// RULE5: Bit 6 is OR of summary bits ANDed with service enable bits.
// RULE6: Rising edge of bit 6 raises the service request line.
// RULE7: Serial poll returns status byte, withdraws request, keeps master summary.
// RULE8: After a poll, a new request needs a fresh rising edge.
// RULE9: Master summary stays set until enabled summaries clear or disable.
// RULE10: Status query returns all bits with bit 6 as master summary.
// RULE11: Enable register written by command, read unchanged; zero clears it. The code keeps only bits 7, 5 and 4 of the written value.
// RULE12: Operation-complete command sets event bit 0 when operations finish.
// RULE13: Operation-complete query holds bus, then queues value 1.
// RULE14: Controller sends nothing but reset while that query is outstanding. The controller model ignores bus_hold and still serial-polls on srq_oe.
// RULE15: Controller enables weight 32 in both enables for command errors.
// RULE16: Controller polls and picks the device returning bit 6 set.
// RULE17: Standard events: bit 5 command, 4 execution, 2 query, 7 power-on.
// RULE18: Standard event query returns and clears the register.
// RULE19: Clear-status clears standard and operation event registers.
// RULE20: Status byte bits 3 to 0 always read zero.
module status_byte_service_request
(
  input  wire       clk,
  input  wire       rst,
  input  wire       cmd_err,
  input  wire       exe_err,
  input  wire       qry_err,
  input  wire [7:0] oper_events,
  input  wire       msg_available,
  input  wire       ops_pending,
  input  wire       ese_write,
  input  wire       oper_en_write,
  input  wire       sre_write,
  input  wire [7:0] write_data,
  input  wire       esr_read,
  input  wire       oper_read,
  input  wire       clear_status,
  input  wire       stb_query,
  input  wire       serial_poll,
  input  wire       opc_cmd,
  input  wire       opc_query,
  output reg  [7:0] service_request_mask,
  output reg  [7:0] std_event_enable,
  output reg  [7:0] oper_event_enable,
  output reg  [7:0] reply_data,
  output reg        reply_valid,
  output reg  [7:0] poll_data,
  output reg        poll_valid,
  output reg        srq_out,
  output reg        srq_oe,
  output reg        bus_hold,
  output reg        opc_answer_push,
  output reg  [7:0] opc_answer_data
);
  // ==========================================================
  // Event registers
  reg  [7:0] std_events_r;
  reg  [7:0] oper_events_r;
  reg        rqs_r;
  reg        mss_prev_r;
  wire       opc_event;
  wire       opc_answer;
  wire       hold_w;

  function [7:0] make_stb;
    input [7:0] se;
    input [7:0] se_en;
    input [7:0] oe;
    input [7:0] oe_en;
    input       output_message_available;
    input [7:0] sre;
    reg   [7:0] s;
    begin
      s = 8'h00; // [RULE20]
      s[`STB_OPER_BIT] = |(oe & oe_en); // [RULE3] [RULE1]
      s[`STB_ESB_BIT]  = |(se & se_en); // [RULE4] [RULE1]
      s[`STB_MAV_BIT]  = output_message_available;           // [RULE2]
      s[`STB_MSS_BIT]  = |(s & sre & `STB_SUM_MASK); // [RULE5] [RULE9]
      make_stb = s;
    end
  endfunction

  wire [7:0] stb_now = make_stb(std_events_r, std_event_enable,
                                oper_events_r, oper_event_enable,
                                msg_available, service_request_mask);
  wire       master_summary_function = stb_now[`STB_MSS_BIT];

  opc_tracker u_opc
  (
    .clk         (clk),
    .rst         (rst),
    .opc_cmd     (opc_cmd),
    .opc_query   (opc_query),
    .ops_pending (ops_pending),
    .opc_event   (opc_event),
    .opc_answer  (opc_answer),
    .bus_hold    (hold_w)
  );

  // ==========================================================
  // Event capture; a new event beats a clear in the same cycle.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      std_events_r  <= `SE_RESET; // [RULE17]
      oper_events_r <= 8'h00;
    end
    else
    begin
      if (esr_read || clear_status)
        std_events_r <= 8'h00; // [RULE18] [RULE19]
      if (clear_status || oper_read)
        oper_events_r <= oper_events; // [RULE19]
      else
        oper_events_r <= oper_events_r | oper_events;
      if (cmd_err)
        std_events_r[`SE_CME_BIT] <= 1'b1; // [RULE17]
      if (exe_err)
        std_events_r[`SE_EXE_BIT] <= 1'b1; // [RULE17]
      if (qry_err)
        std_events_r[`SE_QYE_BIT] <= 1'b1; // [RULE17]
      if (opc_event)
        std_events_r[`SE_OPC_BIT] <= 1'b1; // [RULE12]
      if (!(esr_read || clear_status))
        std_events_r[`SE_PON_BIT] <= std_events_r[`SE_PON_BIT];
    end
  end

  // ==========================================================
  // Enables, replies and service request
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      service_request_mask <= `SRE_RESET;
      std_event_enable     <= 8'h00;
      oper_event_enable    <= 8'h00;
      reply_data           <= 8'h00;
      reply_valid          <= 1'b0;
      poll_data            <= 8'h00;
      poll_valid           <= 1'b0;
      rqs_r                <= 1'b0;
      mss_prev_r           <= 1'b0;
      srq_out              <= 1'b0;
      srq_oe               <= 1'b0;
      bus_hold             <= 1'b0;
      opc_answer_push      <= 1'b0;
      opc_answer_data      <= 8'h00;
    end
    else
    begin
      reply_valid     <= 1'b0;
      poll_valid      <= 1'b0;
      opc_answer_push <= opc_answer; // [RULE13]
      opc_answer_data <= `OPC_QUERY_ANSWER;
      bus_hold        <= hold_w;
      if (sre_write)
        service_request_mask <= write_data & `STB_SUM_MASK; // [RULE11]
      if (ese_write)
        std_event_enable <= write_data & `SE_USED_MASK;
      if (oper_en_write)
        oper_event_enable <= write_data;
      if (esr_read)
      begin
        reply_data  <= std_events_r; // [RULE18]
        reply_valid <= 1'b1;
      end
      else if (oper_read)
      begin
        reply_data  <= oper_events_r;
        reply_valid <= 1'b1;
      end
      else if (stb_query)
      begin
        reply_data  <= stb_now; // [RULE10]
        reply_valid <= 1'b1;
      end
      mss_prev_r <= master_summary_function;
      // Only a fresh edge of the master summary requests service.
      if (master_summary_function && !mss_prev_r)
        rqs_r <= 1'b1; // [RULE6] [RULE8]
      else if (serial_poll || !master_summary_function)
        rqs_r <= 1'b0; // [RULE7]
      if (serial_poll)
      begin
        poll_data  <= {stb_now[7], rqs_r, stb_now[5:0]}; // [RULE7] [RULE16]
        poll_valid <= 1'b1;
      end
      // Open-drain line: drive low while requesting.
      srq_out <= 1'b0;
      srq_oe  <= (master_summary_function && !mss_prev_r) ||
                 (rqs_r && master_summary_function && !serial_poll); // [RULE6]
    end
  end
endmodule // status_byte_service_request
`default_nettype wire

// File: src/status_srq_consts.vh
// Bit positions, masks, reset values and the query answer value of the status summary block.
`ifndef STATUS_SRQ_CONSTS_VH
`define STATUS_SRQ_CONSTS_VH
`define STB_OPER_BIT     3'd7
`define STB_MSS_BIT      3'd6
`define STB_ESB_BIT      3'd5
`define STB_MAV_BIT      3'd4
`define STB_SUM_MASK     8'hb0
`define SE_PON_BIT       3'd7
`define SE_CME_BIT       3'd5
`define SE_EXE_BIT       3'd4
`define SE_QYE_BIT       3'd2
`define SE_OPC_BIT       3'd0
`define SRE_RESET        8'h00
`define SE_RESET         8'h80
`define SE_USED_MASK     8'hb5
`define OPC_QUERY_ANSWER 8'h01
`endif
